// >>> tpcs_params.svh
`ifndef TPCS_PARAMS_SVH
`define TPCS_PARAMS_SVH

// Data widths of the low-rate results (signed two's complement fractions)
`define TPCS_DW 24
// Channel switch ratio is unsigned fixed point, 1 integer bit + 23 fraction bits
`define TPCS_RATIO_FRAC 23
// Meter configuration encodings
`define TPCS_METER_CONFIG_SELECT_ONE_LINE_NEUTRAL 2'h0
`define TPCS_METER_CONFIG_SELECT_TWO_LINE 2'h1
// Reset values
`define TPCS_RST_SEL 1'b0
`define TPCS_RST_TOTAL 24'h000000
// Cycles from a new-average strobe to total update: compare stage, then output stage
`define TPCS_LATENCY 2

`endif

// >>> tpcs_pkg.sv
`include "tpcs_params.svh"

package tpcs_pkg;
  typedef logic signed [`TPCS_DW-1:0] tpcs_word_t;
  typedef logic [`TPCS_DW-1:0] tpcs_mag_t;
  typedef enum logic [1:0] {TPCS_IDLE, TPCS_SELECT, TPCS_UPDATE} tpcs_state_e;
endpackage

// >>> tpcs_channel_picker.sv
`timescale 1ns/1ps
`include "tpcs_params.svh"

// Decides which channel feeds the totals in line-plus-neutral mode
module tpcs_channel_picker
  import tpcs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // Evaluation strobe
  input wire logic eval_i,
  // Metrics and thresholds
  input wire logic select_by_current_flag_i,
  input wire tpcs_word_t ch1_avg_active_i,
  input wire tpcs_word_t ch2_avg_active_i,
  input wire tpcs_mag_t ch1_rms_current_i,
  input wire tpcs_mag_t ch2_rms_current_i,
  input wire tpcs_mag_t min_select_amplitude_i,
  input wire tpcs_mag_t min_select_current_i,
  input wire tpcs_mag_t channel_switch_ratio_i,
  // Manual override
  input wire logic auto_select_hold_i,
  input wire logic forced_channel_i,
  // Selected channel, 0 = channel 1, 1 = channel 2
  output logic sel_ch2_o
);

  logic sel_ch2;
  logic next_sel_ch2;
  tpcs_mag_t m1;
  tpcs_mag_t m2;
  tpcs_mag_t mmin;
  tpcs_mag_t m_act;
  tpcs_mag_t m_oth;
  logic [2*`TPCS_DW-1:0] scaled;
  logic [2*`TPCS_DW-1:0] oth_wide;
  logic auto_ok;
  logic switch_ok;

  // Magnitude of a signed power result; most negative value saturates
  function automatic tpcs_mag_t mag(input tpcs_word_t v);
    tpcs_word_t n;
    begin
      n = -v;
      if (!v[`TPCS_DW-1])
        mag = tpcs_mag_t'(v);
      else if (n[`TPCS_DW-1])
        mag = {1'b0, {(`TPCS_DW-1){1'b1}}};
      else
        mag = tpcs_mag_t'(n);
    end
  endfunction

  // Metric choice and hysteresis compare
  always_comb
  begin
    m1 = select_by_current_flag_i ? ch1_rms_current_i : mag(ch1_avg_active_i);
    m2 = select_by_current_flag_i ? ch2_rms_current_i : mag(ch2_avg_active_i);
    mmin = select_by_current_flag_i ? min_select_current_i : min_select_amplitude_i;
    m_act = sel_ch2 ? m2 : m1;
    m_oth = sel_ch2 ? m1 : m2;
    auto_ok = (m1 > mmin) || (m2 > mmin);
    // Ratio product is kept full width so a ratio above 1.0 cannot wrap
    scaled = {{`TPCS_DW{1'b0}}, m_act} * {{`TPCS_DW{1'b0}}, channel_switch_ratio_i};
    // Other metric aligned to the ratio's binary point; strict compare gives the hysteresis
    oth_wide = {{(`TPCS_DW-`TPCS_RATIO_FRAC){1'b0}}, m_oth, {`TPCS_RATIO_FRAC{1'b0}}};
    switch_ok = oth_wide > scaled;
    next_sel_ch2 = sel_ch2;
    if (eval_i)
    begin
      if (auto_select_hold_i)
        next_sel_ch2 = forced_channel_i;
      else if (auto_ok && switch_ok)
        next_sel_ch2 = ~sel_ch2;
    end
  end

  // Starts on channel 1 in automatic mode without any setup
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      sel_ch2 <= `TPCS_RST_SEL;
    else
      sel_ch2 <= next_sel_ch2;
  end

  assign sel_ch2_o = sel_ch2;

  chk_hold_forces: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eval_i && auto_select_hold_i |=> sel_ch2 == $past(forced_channel_i))
    else $error("Hold did not force the channel");
  chk_min_gate: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eval_i && !auto_select_hold_i && !auto_ok |=> $stable(sel_ch2))
    else $error("Channel changed below minimum amplitude");
  chk_hysteresis_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eval_i && !auto_select_hold_i && !switch_ok |=> $stable(sel_ch2))
    else $error("Channel changed inside hysteresis band");
  chk_switch_taken: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eval_i && !auto_select_hold_i && auto_ok && switch_ok |=> sel_ch2 != $past(sel_ch2))
    else $error("Channel switch missed");
  chk_no_eval_stable: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !eval_i |=> $stable(sel_ch2))
    else $error("Selection moved outside evaluation");
  cov_auto_switch: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eval_i && !auto_select_hold_i && auto_ok && switch_ok);
  cov_hyst_block: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    eval_i && auto_ok && !switch_ok && (m_oth > m_act));
endmodule

// >>> tpcs_total_power.sv
`timescale 1ns/1ps
`include "tpcs_params.svh"

// Functional notes
// - Two-line mode 01: each total is half the sum of both channels.
// - Mode 00 default: totals copy the selected channel's three averages.
// - Automatic selection is active from reset with no software setup.
// - Metric is averaged active power when flag is 0, RMS current when 1.
// - Automatic changes allowed only while some channel metric exceeds the minimum.
// - Automatic selection toggles between the channels on a strobe, comparing metric magnitudes.
// - Switch only when other metric exceeds active metric times switch ratio.
// - Active metric dropping below the other does not switch by itself.
// - Hold bit disables automatic choice; forced-channel bit picks the channel.
module tpcs_total_power
  import tpcs_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_n_i,
  // New averages strobe, one cycle per averaging interval
  input wire logic avg_valid_i,
  // Channel 1 averages
  input wire tpcs_word_t ch1_avg_active_i,
  input wire tpcs_word_t ch1_avg_reactive_i,
  input wire tpcs_word_t ch1_avg_apparent_i,
  input wire tpcs_mag_t ch1_rms_current_i,
  // Channel 2 averages
  input wire tpcs_word_t ch2_avg_active_i,
  input wire tpcs_word_t ch2_avg_reactive_i,
  input wire tpcs_word_t ch2_avg_apparent_i,
  input wire tpcs_mag_t ch2_rms_current_i,
  // Configuration bits
  input wire logic [1:0] meter_config_select_i,
  input wire logic select_by_current_flag_i,
  input wire tpcs_mag_t min_select_amplitude_i,
  input wire tpcs_mag_t min_select_current_i,
  input wire tpcs_mag_t channel_switch_ratio_i,
  input wire logic auto_select_hold_i,
  input wire logic forced_channel_i,
  // Totals and status
  output tpcs_word_t total_active_o,
  output tpcs_word_t total_reactive_o,
  output tpcs_word_t total_apparent_o,
  output logic total_valid_o,
  output logic active_ch2_o
);

  tpcs_state_e state;
  tpcs_state_e next_state;
  tpcs_word_t p1, q1, s1, p2, q2, s2;
  tpcs_word_t next_p1, next_q1, next_s1, next_p2, next_q2, next_s2;
  tpcs_word_t tot_p, tot_q, tot_s;
  tpcs_word_t next_tot_p, next_tot_q, next_tot_s;
  logic tot_valid;
  logic next_tot_valid;
  logic act_ch2;
  logic next_act_ch2;
  logic eval;
  logic sel_ch2;

  // Half of a sum; widened so two full-scale values do not overflow
  function automatic tpcs_word_t half_sum(input tpcs_word_t a, input tpcs_word_t b);
    logic signed [`TPCS_DW:0] s;
    begin
      s = {a[`TPCS_DW-1], a} + {b[`TPCS_DW-1], b};
      half_sum = s[`TPCS_DW:1];
    end
  endfunction

  // Evaluation happens in the cycle the averages arrive, so the pick
  // is settled one cycle before the totals are written
  assign eval = avg_valid_i;

  tpcs_channel_picker u_picker (
    .sys_clk_i(sys_clk_i),
    .rst_n_i(rst_n_i),
    .eval_i(eval),
    .select_by_current_flag_i(select_by_current_flag_i),
    .ch1_avg_active_i(ch1_avg_active_i),
    .ch2_avg_active_i(ch2_avg_active_i),
    .ch1_rms_current_i(ch1_rms_current_i),
    .ch2_rms_current_i(ch2_rms_current_i),
    .min_select_amplitude_i(min_select_amplitude_i),
    .min_select_current_i(min_select_current_i),
    .channel_switch_ratio_i(channel_switch_ratio_i),
    .auto_select_hold_i(auto_select_hold_i),
    .forced_channel_i(forced_channel_i),
    .sel_ch2_o(sel_ch2)
  );

  // Sequencer, capture and total computation
  always_comb
  begin
    next_state = state;
    next_p1 = p1;
    next_q1 = q1;
    next_s1 = s1;
    next_p2 = p2;
    next_q2 = q2;
    next_s2 = s2;
    next_tot_p = tot_p;
    next_tot_q = tot_q;
    next_tot_s = tot_s;
    next_tot_valid = 1'b0;
    next_act_ch2 = act_ch2;
    case (state)
      TPCS_IDLE:
      begin
        if (avg_valid_i)
        begin
          // Latch the averages so late input changes cannot tear a result
          next_p1 = ch1_avg_active_i;
          next_q1 = ch1_avg_reactive_i;
          next_s1 = ch1_avg_apparent_i;
          next_p2 = ch2_avg_active_i;
          next_q2 = ch2_avg_reactive_i;
          next_s2 = ch2_avg_apparent_i;
          next_state = TPCS_SELECT;
        end
      end
      TPCS_SELECT:
      begin
        if (meter_config_select_i == `TPCS_METER_CONFIG_SELECT_TWO_LINE)
        begin
          next_tot_p = half_sum(p1, p2);
          next_tot_q = half_sum(q1, q2);
          next_tot_s = half_sum(s1, s2);
        end
        else
        begin
          // Other codes are treated as line-plus-neutral
          next_tot_p = sel_ch2 ? p2 : p1;
          next_tot_q = sel_ch2 ? q2 : q1;
          next_tot_s = sel_ch2 ? s2 : s1;
        end
        next_act_ch2 = sel_ch2;
        next_tot_valid = 1'b1;
        next_state = TPCS_UPDATE;
      end
      TPCS_UPDATE:
        next_state = TPCS_IDLE;
      default:
        next_state = TPCS_IDLE;
    endcase
  end

  // Register stage; a strobe during SELECT or UPDATE is dropped, fine
  // because intervals are at least a hundred samples apart
  always_ff @(posedge sys_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state <= TPCS_IDLE;
      p1 <= `TPCS_RST_TOTAL;
      q1 <= `TPCS_RST_TOTAL;
      s1 <= `TPCS_RST_TOTAL;
      p2 <= `TPCS_RST_TOTAL;
      q2 <= `TPCS_RST_TOTAL;
      s2 <= `TPCS_RST_TOTAL;
      tot_p <= `TPCS_RST_TOTAL;
      tot_q <= `TPCS_RST_TOTAL;
      tot_s <= `TPCS_RST_TOTAL;
      tot_valid <= 1'b0;
      act_ch2 <= `TPCS_RST_SEL;
    end
    else
    begin
      state <= next_state;
      p1 <= next_p1;
      q1 <= next_q1;
      s1 <= next_s1;
      p2 <= next_p2;
      q2 <= next_q2;
      s2 <= next_s2;
      tot_p <= next_tot_p;
      tot_q <= next_tot_q;
      tot_s <= next_tot_s;
      tot_valid <= next_tot_valid;
      act_ch2 <= next_act_ch2;
    end
  end

  assign total_active_o = tot_p;
  assign total_reactive_o = tot_q;
  assign total_apparent_o = tot_s;
  assign total_valid_o = tot_valid;
  assign active_ch2_o = act_ch2;

  chk_total_latency: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == TPCS_IDLE && avg_valid_i |-> ##2 total_valid_o)
    else $error("Totals not updated two cycles after averages");
  chk_two_line_sum: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    state == TPCS_IDLE && avg_valid_i && meter_config_select_i == `TPCS_METER_CONFIG_SELECT_TWO_LINE
    ##1 meter_config_select_i == `TPCS_METER_CONFIG_SELECT_TWO_LINE
    |=> total_active_o == half_sum($past(ch1_avg_active_i, 2), $past(ch2_avg_active_i, 2)))
    else $error("Two-line total is not half the sum");
  chk_single_copy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    total_valid_o && active_ch2_o && meter_config_select_i != `TPCS_METER_CONFIG_SELECT_TWO_LINE
    && $past(meter_config_select_i) != `TPCS_METER_CONFIG_SELECT_TWO_LINE
    |-> total_reactive_o == q2)
    else $error("Single-channel total does not copy channel 2");
  chk_ch1_copy: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    total_valid_o && !active_ch2_o && meter_config_select_i != `TPCS_METER_CONFIG_SELECT_TWO_LINE
    && $past(meter_config_select_i) != `TPCS_METER_CONFIG_SELECT_TWO_LINE
    |-> total_active_o == p1)
    else $error("Single-channel total does not copy channel 1");
  chk_reset_auto: assert property (@(posedge sys_clk_i)
    $rose(rst_n_i) |-> !active_ch2_o)
    else $error("Selection not on channel 1 after reset");
  // Totals and the channel flag only move on the update edge
  chk_totals_hold: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    !total_valid_o |-> $stable(total_active_o) && $stable(active_ch2_o))
    else $error("Totals moved without an update");
  chk_valid_pulse: assert property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    total_valid_o |=> !total_valid_o)
    else $error("Update pulse longer than one cycle");
  cov_two_line: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    total_valid_o && meter_config_select_i == `TPCS_METER_CONFIG_SELECT_TWO_LINE);
  cov_ch2_selected: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    total_valid_o && active_ch2_o);
  // Reserved codes fall back to line-plus-neutral
  cov_mode_reserved: cover property (@(posedge sys_clk_i) disable iff (!rst_n_i)
    total_valid_o && meter_config_select_i[1]);
endmodule

// >>> tb_total_power_channel_select.sv
`timescale 1ns/1ps
`include "tpcs_params.svh"

module tb_total_power_channel_select
  import tpcs_pkg::*;
;
  logic sys_clk_i;
  logic rst_n_i;
  logic avg_valid;
  tpcs_word_t c1a, c1r, c1s, c2a, c2r, c2s;
  tpcs_mag_t c1i, c2i, min_amp, min_cur, ratio;
  logic [1:0] mode;
  logic by_cur, hold, forced;
  tpcs_word_t tot_a, tot_r, tot_s;
  logic tot_v, act_ch2;
  int bad_count;
  int total_checks;

  tpcs_total_power uut (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .avg_valid_i(avg_valid),
    .ch1_avg_active_i(c1a), .ch1_avg_reactive_i(c1r), .ch1_avg_apparent_i(c1s),
    .ch1_rms_current_i(c1i), .ch2_avg_active_i(c2a), .ch2_avg_reactive_i(c2r),
    .ch2_avg_apparent_i(c2s), .ch2_rms_current_i(c2i), .meter_config_select_i(mode),
    .select_by_current_flag_i(by_cur), .min_select_amplitude_i(min_amp),
    .min_select_current_i(min_cur), .channel_switch_ratio_i(ratio),
    .auto_select_hold_i(hold), .forced_channel_i(forced), .total_active_o(tot_a),
    .total_reactive_o(tot_r), .total_apparent_o(tot_s), .total_valid_o(tot_v),
    .active_ch2_o(act_ch2)
  );

  // Free-running 20 MHz clock
  initial
  begin
    sys_clk_i = 1'b0;
    forever #25 sys_clk_i = ~sys_clk_i;
  end

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    total_checks++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask

  task automatic report_and_stop();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Floor of half the sum, kept 25 bits wide so the sum never wraps
  function automatic tpcs_word_t half_sum(input tpcs_word_t x, input tpcs_word_t y);
    logic signed [24:0] s;
    s = {x[23], x} + {y[23], y};
    return s[24:1];
  endfunction

  // One averaging interval; reactive and apparent are derived so each total is distinct
  task automatic xfer(input tpcs_word_t a1, input tpcs_word_t a2, input tpcs_mag_t i1,
    input tpcs_mag_t i2, input logic exp_ch2);
    logic two;
    tpcs_word_t ea;
    tpcs_word_t er;
    tpcs_word_t es;
    two = (mode == `TPCS_METER_CONFIG_SELECT_TWO_LINE);
    c1a = a1;
    c1r = -a1;
    c1s = a1 + 24'sh000010;
    c2a = a2;
    c2r = -a2;
    c2s = a2 + 24'sh000010;
    c1i = i1;
    c2i = i2;
    avg_valid = 1'b1;
    @(posedge sys_clk_i);
    #2 avg_valid = 1'b0;
    check("valid_early", 24'h000000, {23'h0, tot_v});
    ea = two ? half_sum(c1a, c2a) : (exp_ch2 ? c2a : c1a);
    er = two ? half_sum(c1r, c2r) : (exp_ch2 ? c2r : c1r);
    es = two ? half_sum(c1s, c2s) : (exp_ch2 ? c2s : c1s);
    @(posedge sys_clk_i);
    #2 check("valid", 24'h000001, {23'h0, tot_v});
    check("total_active", ea, tot_a);
    check("total_reactive", er, tot_r);
    check("total_apparent", es, tot_s);
    if (!two)
      check("active_ch2", {23'h0, exp_ch2}, {23'h0, act_ch2});
    // Pulse must drop after one cycle; this edge also keeps strobes three cycles apart
    @(posedge sys_clk_i);
    #2 check("valid_drop", 24'h000000, {23'h0, tot_v});
    check("totals_stand", ea, tot_a);
  endtask

  task automatic s_reset();
    check("reset_active", 24'h000000, tot_a);
    check("reset_valid", 24'h000000, {23'h0, tot_v});
    check("reset_ch2", 24'h000000, {23'h0, act_ch2});
  endtask

  task automatic s_power_select();
    xfer(24'sh0003e8, 24'sh0007d0, 24'h0, 24'h0, 1'b1);
    xfer(24'sh0003f2, 24'sh0003e8, 24'h0, 24'h0, 1'b1);
    xfer(24'sh000406, 24'sh0003e8, 24'h0, 24'h0, 1'b0);
    xfer(24'sh000406, -24'sh000bb8, 24'h0, 24'h0, 1'b1);
  endtask

  // Equal to the minimum is not above it, so no change yet
  task automatic s_min_gate();
    xfer(24'sh000064, 24'sh00000a, 24'h0, 24'h0, 1'b1);
    xfer(24'sh000065, 24'sh00000a, 24'h0, 24'h0, 1'b0);
  endtask

  task automatic s_current_metric();
    by_cur = 1'b1;
    xfer(24'sh001388, 24'sh00000a, 24'h0000c8, 24'h000190, 1'b1);
    by_cur = 1'b0;
  endtask

  // Reset in mid-run while channel 2 is selected must return to automatic on channel 1
  task automatic s_mid_reset();
    rst_n_i = 1'b0;
    #1 check("mid_reset_ch2", 24'h000000, {23'h0, act_ch2});
    check("mid_reset_active", 24'h000000, tot_a);
    repeat (3) @(posedge sys_clk_i);
    #2 rst_n_i = 1'b1;
    check("mid_release_valid", 24'h000000, {23'h0, tot_v});
    check("mid_release_ch2", 24'h000000, {23'h0, act_ch2});
  endtask

  task automatic s_hold();
    hold = 1'b1;
    xfer(24'sh00000a, 24'sh001388, 24'h0, 24'h0, 1'b0);
    forced = 1'b1;
    xfer(24'sh001388, 24'sh00000a, 24'h0, 24'h0, 1'b1);
    hold = 1'b0;
    xfer(24'sh001388, 24'sh00000a, 24'h0, 24'h0, 1'b0);
  endtask

  task automatic s_two_line();
    mode = `TPCS_METER_CONFIG_SELECT_TWO_LINE;
    xfer(24'sh0003e9, -24'sh000004, 24'h0, 24'h0, 1'b0);
    xfer(-24'sh000003, 24'sh000000, 24'h0, 24'h0, 1'b0);
    // Reserved code 10 behaves as line-plus-neutral
    mode = 2'h2;
    xfer(24'sh00000a, 24'sh001388, 24'h0, 24'h0, 1'b1);
  endtask

  // Main sequence
  initial
  begin
    bad_count = 0;
    total_checks = 0;
    rst_n_i = 1'b0;
    avg_valid = 1'b0;
    {c1a, c1r, c1s, c2a, c2r, c2s} = '0;
    c1i = 24'h0;
    c2i = 24'h0;
    mode = `TPCS_METER_CONFIG_SELECT_ONE_LINE_NEUTRAL;
    by_cur = 1'b0;
    min_amp = 24'h000064;
    min_cur = 24'h000064;
    ratio = 24'h828f5c;
    hold = 1'b0;
    forced = 1'b0;
    repeat (3) @(posedge sys_clk_i);
    #2 rst_n_i = 1'b1;
    s_reset();
    s_power_select();
    s_min_gate();
    s_current_metric();
    s_mid_reset();
    s_hold();
    s_two_line();
    report_and_stop();
  end
endmodule
